// *** rtl/ptc_top.v ***
// Operation
// - Count register is read-only; writes to it change nothing.
// - Count clears on reset, limit write, or changed source or divider select.
// - Each prescaler tick increments count until it equals limit, then wraps to zero.
// - With limit zero the flag sets on every prescaler tick.
// - Any limit write clears prescaler and count, whatever value.
// - Match limit resets to zero.
// - After reset the counter is stopped at zero, prescaler off.
// - After reset the low-power oscillator is the selected source.
// - Divider code zero keeps prescaler off; nonzero starts it.
// - Three sources: low-power oscillator, external and internal reference.
// - Writing a different source select clears prescaler and count.
// - Writing a different divider select clears prescaler and count.
// - Divide ratio comes from divider code and source select bit 0.
// - Flag sets when count passes from limit to zero.
// - Interrupt request is flag and enable together.
// - Writing one to the flag clears flag and request unless a wrap in that cycle sets the flag.
// - Writing zero to flag does nothing; reset clears flag, enable, selects.
// - Control layout: flag 7, source 6:5, enable 4, divider 3:0.
// - Source code 00 low-power, 01 external, 1x internal.
// - Ratio table: binary and decimal values per source bit 0.
`timescale 1ns/1ps
`include "ptc_regs.vh"

module ptc_top
(
  input  wire        ref_clk_i,
  input  wire        arst_n_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire        wb_ack_o,
  input  wire        low_power_osc_clock_i,
  input  wire        external_ref_clock_i,
  input  wire        internal_ref_clock_i,
  output wire        tick_irq_o
);

  // Reset release synchroniser.
  reg         rst_meta_ff;
  reg         rst_sync_ff;
  wire        rst_n;

  // Source clock synchronisers and edge detection.
  wire [2:0]  src_raw;
  reg  [2:0]  src_meta_ff;
  reg  [2:0]  src_sync_ff;
  reg  [2:0]  src_prev_ff;
  wire [2:0]  src_rise;
  reg         src_tick;

  // Register state.
  // Each control field keeps its own flip-flop with its own next value.
  reg         tick_flag_ff;
  reg         nxt_tick_flag;
  reg  [1:0]  source_select_ff;
  reg  [1:0]  nxt_source_select;
  reg         tick_irq_enable_ff;
  reg         nxt_tick_irq_enable;
  reg  [3:0]  divider_select_ff;
  reg  [3:0]  nxt_divider_select;
  reg  [7:0]  tick_match_limit_ff;
  reg  [7:0]  nxt_tick_match_limit;
  reg  [7:0]  tick_count_ff;
  reg  [7:0]  nxt_tick_count;
  reg         tick_irq_ff;

  // Bus slave state.
  // Read data is held in a flip-flop so the master sees a stable value.
  reg         ack_ff;
  reg  [31:0] rd_data_ff;
  reg  [31:0] nxt_rd_data;

  // Decoded access strobes.
  // All but presc_tick, a prescaler flip-flop output, are combinational and settle well within one bus cycle.
  wire        bus_req;
  wire        wr_now;
  wire [7:0]  word_adr;
  wire        hit_sc;
  wire        hit_count;
  wire        hit_limit;
  wire        wr_sc;
  wire        wr_limit;
  wire [1:0]  wr_source;
  wire [3:0]  wr_divider;
  wire        source_changed;
  wire        divider_changed;
  wire        chain_clear;
  wire        presc_tick;
  wire        wrap_event;
  wire [7:0]  sc_value;

  // Reset is asserted at once but released only after two clean edges,
  // so no flip-flop leaves reset on a metastable release.
  // The price is two cycles of extra reset after the pin rises, so the
  // first bus request must wait until the third edge after release.
  always @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  assign rst_n = rst_sync_ff;

  // Source clocks in select-code order.
  // Index 0 is the low-power source that reset selects by default.
  assign src_raw = {internal_ref_clock_i, external_ref_clock_i, low_power_osc_clock_i};

  // Each source clock arrives from its own oscillator and is sampled by two
  // flip-flops; only the second stage and later feed the edge detector.
  // The sources must run well below half the bus clock for no edge to be lost.
  // All three are sampled all the time, so a source switch finds its
  // synchroniser already settled and needs no extra flush cycles.
  // The detector starts low, so a source that is high at reset release
  // gives one early edge; the divider is off then, so it is harmless.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_src_sync
      always @(posedge ref_clk_i or negedge rst_n)
      begin
        if (!rst_n)
        begin
          src_meta_ff[gi] <= 1'b0;
          src_sync_ff[gi] <= 1'b0;
          src_prev_ff[gi] <= 1'b0;
        end
        else
        begin
          src_meta_ff[gi] <= src_raw[gi];
          src_sync_ff[gi] <= src_meta_ff[gi];
          src_prev_ff[gi] <= src_sync_ff[gi];
        end
      end
      assign src_rise[gi] = src_sync_ff[gi] & ~src_prev_ff[gi];
    end
  endgenerate

  // Pick the rising edge of the selected source; bit 1 set means internal.
  // Both codes with bit 1 set pick the internal source; bit 0 of those
  // codes still steers the divide ratio table.
  always @*
  begin
    src_tick = 1'b0;
    case (source_select_ff)
      `PTC_SRC_LPO: src_tick = src_rise[0];
      `PTC_SRC_EXT: src_tick = src_rise[1];
      default:      src_tick = src_rise[2];
    endcase
  end

  // Wishbone decode. Only byte lane 0 carries register data; the upper lanes
  // are accepted and ignored so a full-word write works as well.
  // Writes act on the edge where ack is high, so each acknowledged access
  // changes a register exactly once.
  assign bus_req   = wb_cyc_i & wb_stb_i;
  assign wr_now    = bus_req & ack_ff & wb_we_i & wb_sel_i[0];
  assign word_adr  = {wb_adr_i[7:2], 2'b00};
  assign hit_sc    = (word_adr == `PTC_ADR_STATUS_CONTROL);
  assign hit_count = (word_adr == `PTC_ADR_COUNT);
  assign hit_limit = (word_adr == `PTC_ADR_MATCH_LIMIT);
  assign wr_sc     = wr_now & hit_sc;
  assign wr_limit  = wr_now & hit_limit;

  // Written fields of the control register.
  assign wr_source  = wb_dat_i[`PTC_SC_SRC_HI:`PTC_SC_SRC_LO];
  assign wr_divider = wb_dat_i[`PTC_SC_DIV_HI:`PTC_SC_DIV_LO];

  // Rewriting the same select values leaves the running chain alone; only
  // a real change restarts it, so software can touch the flag freely.
  // Limit writes always restart the chain, even with an unchanged value.
  assign source_changed  = wr_sc & (wr_source != source_select_ff);
  assign divider_changed = wr_sc & (wr_divider != divider_select_ff);
  assign chain_clear     = wr_limit | source_changed | divider_changed;

  // Prescaler: turns selected source edges into counter enables.
  // It runs on the bus clock too, so the counter never crosses a clock
  // domain; the price is that a source must stay slower than the bus clock.
  ptc_prescaler u_prescaler
  (
    .clk_i      (ref_clk_i),
    .rst_n_i    (rst_n),
    .clear_i    (chain_clear),
    .src_tick_i (src_tick),
    .sel0_i     (source_select_ff[0]),
    .div_sel_i  (divider_select_ff),
    .tick_o     (presc_tick)
  );

  // A prescaler tick while the count sits at the limit is the wrap.
  // With a limit of zero this happens on every tick.
  // A restart in the same cycle drops the pending wrap, as the count restarts.
  assign wrap_event = presc_tick & (tick_count_ff == tick_match_limit_ff) & ~chain_clear;

  // Only one branch below acts in a cycle, so the count moves by at most one.
  // Main counter. A restart has priority over a pending tick so the count
  // always starts from zero after software reconfigures the chain.
  always @*
  begin
    nxt_tick_count = tick_count_ff;
    if (chain_clear)
    begin
      nxt_tick_count = `PTC_RST_COUNT;
    end
    else if (wrap_event)
    begin
      nxt_tick_count = `PTC_RST_COUNT;
    end
    else if (presc_tick)
    begin
      nxt_tick_count = tick_count_ff + 8'h01;
    end
  end

  // Control fields. The count register has no write path at all.
  // All three fields of the control register are taken from one write;
  // the flag bit is handled on its own below since it clears on a one.
  always @*
  begin
    nxt_source_select    = source_select_ff;
    nxt_divider_select   = divider_select_ff;
    nxt_tick_irq_enable  = tick_irq_enable_ff;
    nxt_tick_match_limit = tick_match_limit_ff;
    if (wr_sc)
    begin
      nxt_source_select   = wr_source;
      nxt_divider_select  = wr_divider;
      nxt_tick_irq_enable = wb_dat_i[`PTC_SC_IE_BIT];
    end
    if (wr_limit)
    begin
      nxt_tick_match_limit = wb_dat_i[7:0];
    end
  end

  // Flag: a wrap in the same cycle as a clearing write wins, so no event
  // is lost; writing zero to the flag bit leaves it as it is.
  // Software that clears the flag right after a wrap cannot lose the next
  // one, as the set side is checked last.
  always @*
  begin
    nxt_tick_flag = tick_flag_ff;
    if (wr_sc && wb_dat_i[`PTC_SC_FLAG_BIT])
    begin
      nxt_tick_flag = 1'b0;
    end
    if (wrap_event)
    begin
      nxt_tick_flag = 1'b1;
    end
  end

  // State registers; everything starts stopped with the low-power source.
  // The interrupt loads from next-state values, so it changes on the same
  // edge as the flag and the enable and still leaves from a flip-flop.
  always @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_flag_ff        <= 1'b0;
      source_select_ff    <= `PTC_RST_SRC;
      tick_irq_enable_ff  <= 1'b0;
      divider_select_ff   <= `PTC_RST_DIV;
      tick_match_limit_ff <= `PTC_RST_LIMIT;
      tick_count_ff       <= `PTC_RST_COUNT;
      tick_irq_ff         <= 1'b0;
    end
    else
    begin
      tick_flag_ff        <= nxt_tick_flag;
      source_select_ff    <= nxt_source_select;
      tick_irq_enable_ff  <= nxt_tick_irq_enable;
      divider_select_ff   <= nxt_divider_select;
      tick_match_limit_ff <= nxt_tick_match_limit;
      tick_count_ff       <= nxt_tick_count;
      tick_irq_ff         <= nxt_tick_flag & nxt_tick_irq_enable;
    end
  end

  // Read view of the control register.
  // Bits line up with the field layout that writes use.
  assign sc_value = {tick_flag_ff, source_select_ff, tick_irq_enable_ff, divider_select_ff};

  // Read mux. Unmapped addresses read as zero; upper bits always read zero.
  // The address is decoded on the full word, so byte offsets inside a
  // register word read the same register.
  always @*
  begin
    nxt_rd_data = 32'h00000000;
    if (hit_sc)
    begin
      nxt_rd_data = {24'h000000, sc_value};
    end
    else if (hit_count)
    begin
      nxt_rd_data = {24'h000000, tick_count_ff};
    end
    else if (hit_limit)
    begin
      nxt_rd_data = {24'h000000, tick_match_limit_ff};
    end
  end

  // Ack rises one cycle after the request and drops the cycle after, since
  // it is held low while it is already high. Read data is captured when the
  // request is first seen; the master holds the address meanwhile.
  // A held request is answered again every second cycle; masters are
  // expected to drop cyc and stb for a cycle between accesses.
  always @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_ff     <= 1'b0;
      rd_data_ff <= 32'h00000000;
    end
    else
    begin
      ack_ff <= bus_req & ~ack_ff;
      if (bus_req && !ack_ff)
      begin
        rd_data_ff <= nxt_rd_data;
      end
    end
  end

  // Every output comes straight from a flip-flop, so none can glitch.
  assign wb_ack_o   = ack_ff;
  assign wb_dat_o   = rd_data_ff;
  assign tick_irq_o = tick_irq_ff;

endmodule // ptc_top

// *** pkg/ptc_regs.vh ***
`ifndef PTC_REGS_VH
`define PTC_REGS_VH

// Byte addresses of the three registers on the Wishbone slave.
`define PTC_ADR_STATUS_CONTROL  8'h00
`define PTC_ADR_COUNT           8'h04
`define PTC_ADR_MATCH_LIMIT     8'h08

// Field positions inside tick_status_control.
`define PTC_SC_FLAG_BIT         7
`define PTC_SC_SRC_HI           6
`define PTC_SC_SRC_LO           5
`define PTC_SC_IE_BIT           4
`define PTC_SC_DIV_HI           3
`define PTC_SC_DIV_LO           0

// Reset values.
`define PTC_RST_COUNT           8'h00
`define PTC_RST_LIMIT           8'h00
`define PTC_RST_SRC             2'h0
`define PTC_RST_DIV             4'h0

// Source select codes.
`define PTC_SRC_LPO             2'h0
`define PTC_SRC_EXT             2'h1

// Divider select code that stops the prescaler.
`define PTC_DIV_OFF             4'h0

// Divide ratios with source select bit 0 clear.
`define PTC_DIV_B0_1            18'h00008
`define PTC_DIV_B0_2            18'h00020
`define PTC_DIV_B0_3            18'h00040
`define PTC_DIV_B0_4            18'h00080
`define PTC_DIV_B0_5            18'h00100
`define PTC_DIV_B0_6            18'h00200
`define PTC_DIV_B0_7            18'h00400
`define PTC_DIV_B0_8            18'h00001
`define PTC_DIV_B0_9            18'h00002
`define PTC_DIV_B0_10           18'h00004
`define PTC_DIV_B0_11           18'h0000a
`define PTC_DIV_B0_12           18'h00010
`define PTC_DIV_B0_13           18'h00064
`define PTC_DIV_B0_14           18'h001f4
`define PTC_DIV_B0_15           18'h003e8

// Divide ratios with source select bit 0 set.
`define PTC_DIV_B1_1            18'h00400
`define PTC_DIV_B1_2            18'h00800
`define PTC_DIV_B1_3            18'h01000
`define PTC_DIV_B1_4            18'h02000
`define PTC_DIV_B1_5            18'h04000
`define PTC_DIV_B1_6            18'h08000
`define PTC_DIV_B1_7            18'h10000
`define PTC_DIV_B1_8            18'h003e8
`define PTC_DIV_B1_9            18'h007d0
`define PTC_DIV_B1_10           18'h01388
`define PTC_DIV_B1_11           18'h02710
`define PTC_DIV_B1_12           18'h04e20
`define PTC_DIV_B1_13           18'h0c350
`define PTC_DIV_B1_14           18'h186a0
`define PTC_DIV_B1_15           18'h30d40

// A ratio of zero marks the prescaler as off.
`define PTC_DIV_NONE            18'h00000
`define PTC_DIV_ONE             18'h00001

`endif

// *** rtl/ptc_prescaler.v ***
`timescale 1ns/1ps
`include "ptc_regs.vh"

module ptc_prescaler
(
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire        clear_i,
  input  wire        src_tick_i,
  input  wire        sel0_i,
  input  wire [3:0]  div_sel_i,
  output wire        tick_o
);

  reg  [17:0] ratio;
  reg  [17:0] cnt_ff;
  reg  [17:0] nxt_cnt;
  reg         tick_ff;
  reg         nxt_tick;

  // Ratio lookup from source bit 0 and the divider code; zero means off.
  always @*
  begin
    ratio = `PTC_DIV_NONE;
    case ({sel0_i, div_sel_i})
      5'h01: ratio = `PTC_DIV_B0_1;
      5'h02: ratio = `PTC_DIV_B0_2;
      5'h03: ratio = `PTC_DIV_B0_3;
      5'h04: ratio = `PTC_DIV_B0_4;
      5'h05: ratio = `PTC_DIV_B0_5;
      5'h06: ratio = `PTC_DIV_B0_6;
      5'h07: ratio = `PTC_DIV_B0_7;
      5'h08: ratio = `PTC_DIV_B0_8;
      5'h09: ratio = `PTC_DIV_B0_9;
      5'h0a: ratio = `PTC_DIV_B0_10;
      5'h0b: ratio = `PTC_DIV_B0_11;
      5'h0c: ratio = `PTC_DIV_B0_12;
      5'h0d: ratio = `PTC_DIV_B0_13;
      5'h0e: ratio = `PTC_DIV_B0_14;
      5'h0f: ratio = `PTC_DIV_B0_15;
      5'h11: ratio = `PTC_DIV_B1_1;
      5'h12: ratio = `PTC_DIV_B1_2;
      5'h13: ratio = `PTC_DIV_B1_3;
      5'h14: ratio = `PTC_DIV_B1_4;
      5'h15: ratio = `PTC_DIV_B1_5;
      5'h16: ratio = `PTC_DIV_B1_6;
      5'h17: ratio = `PTC_DIV_B1_7;
      5'h18: ratio = `PTC_DIV_B1_8;
      5'h19: ratio = `PTC_DIV_B1_9;
      5'h1a: ratio = `PTC_DIV_B1_10;
      5'h1b: ratio = `PTC_DIV_B1_11;
      5'h1c: ratio = `PTC_DIV_B1_12;
      5'h1d: ratio = `PTC_DIV_B1_13;
      5'h1e: ratio = `PTC_DIV_B1_14;
      5'h1f: ratio = `PTC_DIV_B1_15;
      default: ratio = `PTC_DIV_NONE;
    endcase
  end

  // Count source edges; emit one pulse per full ratio of edges.
  always @*
  begin
    nxt_cnt  = cnt_ff;
    nxt_tick = 1'b0;
    if (clear_i || (ratio == `PTC_DIV_NONE))
    begin
      nxt_cnt = `PTC_DIV_NONE;
    end
    else if (src_tick_i)
    begin
      if (cnt_ff == (ratio - `PTC_DIV_ONE))
      begin
        nxt_cnt  = `PTC_DIV_NONE;
        nxt_tick = 1'b1;
      end
      else
      begin
        nxt_cnt = cnt_ff + `PTC_DIV_ONE;
      end
    end
  end

  // The pulse is registered so the counter sees a clean one-cycle enable.
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_ff  <= `PTC_DIV_NONE;
      tick_ff <= 1'b0;
    end
    else
    begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick_o = tick_ff;

endmodule // ptc_prescaler

// *** verification/ptc_checker.sv ***
`timescale 1ns/1ps
module ptc_checker
(
  input wire        ref_clk_i,
  input wire        arst_n_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [7:0]  wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        low_power_osc_clock_i,
  input wire        external_ref_clock_i,
  input wire        internal_ref_clock_i,
  input wire        tick_irq_o
);
  reg  [6:0] ctrl_ff;
  reg  [7:0] lim_ff;
  wire       wr_ack = wb_ack_o & wb_we_i & wb_sel_i[0];
  wire       rd_ack = wb_ack_o & ~wb_we_i;

  // Mirrors update on the acked edge, where the design takes a write.
  always @(posedge ref_clk_i or negedge arst_n_i)
    if (!arst_n_i)
      ctrl_ff <= 7'h00;
    else if (wr_ack && wb_adr_i[7:2] == 6'h00)
      ctrl_ff <= wb_dat_i[6:0];

  // The limit mirror bounds any count a read may return.
  always @(posedge ref_clk_i or negedge arst_n_i)
    if (!arst_n_i)
      lim_ff <= 8'h00;
    else if (wr_ack && wb_adr_i[7:2] == 6'h02)
      lim_ff <= wb_dat_i[7:0];

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  // Steps of one bus access.
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd_ctrl;
    rd_ack && wb_adr_i[7:2] == 6'h00;
  endsequence
  sequence s_rd_cnt;
    rd_ack && wb_adr_i[7:2] == 6'h01;
  endsequence
  sequence s_rd_lim;
    rd_ack && wb_adr_i[7:2] == 6'h02;
  endsequence

  a_ack_follows_req: assert property (s_req |=> wb_ack_o)
    else $error("Ack did not follow a request.");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("Ack stood longer than one cycle.");
  a_upper_bytes_zero: assert property (rd_ack |-> wb_dat_o[31:8] == 24'h0)
    else $error("Read data above the low byte not zero.");
  a_unmapped_reads_zero: assert property (rd_ack && wb_adr_i[7:2] > 6'h02 |-> wb_dat_o == 32'h0)
    else $error("Unmapped read returned data.");
  a_ctrl_readback: assert property (s_rd_ctrl |-> wb_dat_o[6:0] == ctrl_ff)
    else $error("Control fields read back wrong.");
  a_limit_readback: assert property (s_rd_lim |-> wb_dat_o[7:0] == lim_ff)
    else $error("Match limit read back wrong.");
  a_count_in_range: assert property (s_rd_cnt |-> wb_dat_o[7:0] <= lim_ff)
    else $error("Count read above the match limit.");
  // The interrupt flip-flop loads from next-state values, so it moves on the
  // same edge as the enable; compare with the mirror of that same edge.
  a_irq_needs_enable: assert property (tick_irq_o |-> ctrl_ff[4])
    else $error("Interrupt raised with enable clear.");
  a_irq_low_release: assert property ($rose(arst_n_i) |-> !tick_irq_o [*2])
    else $error("Interrupt high after reset.");
endmodule // ptc_checker

bind ptc_top ptc_checker u_ptc_checker
(
  .ref_clk_i, .arst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_dat_o, .wb_ack_o, .low_power_osc_clock_i,
  .external_ref_clock_i, .internal_ref_clock_i, .tick_irq_o
);

// *** verification/ptc_top_test.sv ***
`timescale 1ns/1ps
module ptc_top_test;
  typedef struct {bit w; bit [7:0] a; bit [7:0] d;} ptc_row_t;
  typedef struct {bit [7:0] c; int r; int p; int n;} ptc_rate_t;
  reg         ref_clk_i = 1'b0;
  reg         arst_n_i  = 1'b0;
  reg         cyc       = 1'b0;
  reg         we        = 1'b0;
  reg  [7:0]  adr       = 8'h00;
  reg  [31:0] wdat      = 32'h0;
  reg         low_power_osc_clock       = 1'b0;
  reg         ext       = 1'b0;
  reg         intc      = 1'b0;
  reg  [31:0] q;
  wire [31:0] rdat;
  wire        ack;
  wire        irq;
  int         ph;
  int         err_total;
  int         checks_done;
  // Register accesses; a read expects d back.
  ptc_row_t   rows [12] = '{'{1'b0, 8'h00, 8'h00}, '{1'b0, 8'h08, 8'h00}, '{1'b0, 8'h04, 8'h00},
    '{1'b1, 8'h08, 8'h5a}, '{1'b0, 8'h08, 8'h5a}, '{1'b1, 8'h04, 8'hff}, '{1'b0, 8'h04, 8'h00},
    '{1'b0, 8'h0c, 8'h00}, '{1'b1, 8'h00, 8'h70}, '{1'b0, 8'h00, 8'h70}, '{1'b1, 8'h00, 8'h80},
    '{1'b0, 8'h00, 8'h00}};
  // Control value, ratio, source period in cycles, ticks to wait for.
  ptc_rate_t  rates [4] = '{'{8'h01, 8, 8, 3}, '{8'h4a, 4, 12, 5}, '{8'h28, 1000, 10, 1},
    '{8'h0b, 10, 8, 2}};

  ptc_top u_ptc_top
  (
    .ref_clk_i (ref_clk_i), .arst_n_i (arst_n_i), .wb_cyc_i (cyc), .wb_stb_i (cyc),
    .wb_we_i (we), .wb_adr_i (adr), .wb_sel_i (4'hf), .wb_dat_i (wdat), .wb_dat_o (rdat),
    .wb_ack_o (ack), .low_power_osc_clock_i (low_power_osc_clock), .external_ref_clock_i (ext),
    .internal_ref_clock_i (intc), .tick_irq_o (irq)
  );

  always #4 ref_clk_i = ~ref_clk_i;

  // Sources of 8, 10 and 12 cycles; distinct periods catch a wrong source pick.
  always @(posedge ref_clk_i)
  begin
    ph   <= ph + 1;
    low_power_osc_clock  <= (ph % 8) < 4;
    ext  <= (ph % 10) < 5;
    intc <= (ph % 12) < 6;
  end

  task chk(input [31:0] s, input [31:0] e, input [7:0] id);
  begin
    checks_done = checks_done + 1;
    if (s !== e)
    begin
      err_total = err_total + 1;
      $display("Error item %h expected %h seen %h", id, e, s);
    end
  end
  endtask

  // One classic cycle; request held until ack is sampled high.
  task bus(input bit w, input [7:0] a, input [7:0] d, output [31:0] r);
    int n;
  begin
    @(posedge ref_clk_i);
    cyc  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge ref_clk_i);
      n = n + 1;
    end
    while (ack !== 1'b1);
    chk(n, 32'h2, 8'hac);
    r = rdat;
    cyc <= 1'b0;
  end
  endtask

  task rc(input [7:0] a, input [7:0] e);
  begin
    bus(1'b0, a, 8'h00, q);
    chk(q, {24'h0, e}, a);
  end
  endtask

  task wirq;
    int n;
  begin
    n = 0;
    while (irq !== 1'b1 && n < 200)
    begin
      @(posedge ref_clk_i);
      n = n + 1;
    end
    chk({31'h0, irq}, 32'h1, 8'hee);
  end
  endtask

  task rst;
  begin
    @(posedge ref_clk_i);
    arst_n_i <= 1'b0;
    repeat (10) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
  end
  endtask

  task summarize;
  begin
    $display("Checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask

  // Watchdog: the tests need about 11000 cycles.
  initial
  begin
    repeat (30000) @(posedge ref_clk_i);
    err_total = err_total + 1;
    summarize;
  end

  initial
  begin
    rst;
    foreach (rows[i])
    begin
      bus(rows[i].w, rows[i].a, rows[i].d, q);
      if (!rows[i].w)
        chk(q, {24'h0, rows[i].d}, rows[i].a);
    end
    $display("Test register table done");
    // Limit 0xff keeps the count from wrapping while rates are timed.
    bus(1'b1, 8'h08, 8'hff, q);
    foreach (rates[i])
    begin
      bus(1'b1, 8'h00, rates[i].c, q);
      rc(8'h04, 8'h00);
      repeat (rates[i].n * rates[i].r * rates[i].p + 12) @(posedge ref_clk_i);
      rc(8'h04, rates[i].n[7:0]);
      bus(1'b1, 8'h08, 8'hff, q);
      rc(8'h04, 8'h00);
    end
    $display("Test prescaler rates done");
    bus(1'b1, 8'h08, 8'h00, q);
    bus(1'b1, 8'h00, 8'h18, q);
    wirq;
    // A wrap needs three ticks now, so the clear below cannot race a new set.
    bus(1'b1, 8'h08, 8'h02, q);
    bus(1'b1, 8'h00, 8'h98, q);
    rc(8'h00, 8'h18);
    chk({31'h0, irq}, 32'h0, 8'hee);
    wirq;
    rc(8'h04, 8'h00);
    bus(1'b1, 8'h00, 8'h18, q);
    rc(8'h00, 8'h98);
    $display("Test flag and interrupt done");
    rst;
    chk({31'h0, irq}, 32'h0, 8'hee);
    rc(8'h00, 8'h00);
    rc(8'h04, 8'h00);
    rc(8'h08, 8'h00);
    $display("Test reset in mid-run done");
    summarize;
  end
endmodule // ptc_top_test
